// >>> common/cnfc_pkg.sv
`default_nettype none
package cnfc_pkg;

	// register byte offsets
	localparam logic [7:0] NODE_CTRL_OFS = 8'h00;
	localparam logic [7:0] NODE_STAT_OFS = 8'h04;
	localparam logic [7:0] ERR_CNT_OFS   = 8'h08;
	localparam logic [7:0] WARN_LVL_OFS  = 8'h0c;
	localparam logic [7:0] IRQ_STAT_OFS  = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFS  = 8'h14;
	localparam logic [7:0] TSTAMP_OFS    = 8'h18;
	localparam logic [7:0] MSG_CTRL_OFS  = 8'h1c;
	localparam logic [7:0] EVT_OFS       = 8'h20;

	// node control fields
	localparam int CTRL_INIT_BIT = 0;
	localparam int CTRL_DIS_BIT  = 1;
	localparam int CTRL_STT_BIT  = 2;

	// node status fields
	localparam int STAT_WARN_BIT    = 0;
	localparam int STAT_BUS_OFF_FLAG_BIT    = 1;
	localparam int STAT_SUSPEND_ACKNOWLEDGE_BIT  = 2;

	// interrupt status fields
	localparam int IRQ_WARN_BIT  = 0;
	localparam int IRQ_BUS_OFF_FLAG_BIT  = 1;
	localparam int IRQ_PREW_BIT  = 2;
	localparam int IRQ_ALERT_BIT = 3;
	localparam int IRQ_W         = 4;

	// message object control fields
	localparam int MSG_TRANSMIT_REQUEST_FLAG_BIT   = 0;
	localparam int MSG_NEW_DATA_FLAG_BIT = 1;

	// event register fields (self-clearing protocol-engine strobes)
	localparam int EVT_TXERR_BIT  = 0;
	localparam int EVT_RXERR_BIT  = 1;
	localparam int EVT_OKTX_BIT   = 2;

	// counts and reset values
	localparam logic [7:0] WARN_LVL_RST  = 8'h60;
	localparam logic [8:0] TEC_BUS_OFF_FLAG_LIM  = 9'h0ff;
	localparam logic [8:0] ERR_BUS_OFF_FLAG_LOAD = 9'h001;
	localparam logic [7:0] RECOV_IDLES   = 8'h80;
	localparam logic [8:0] RECOV_WARN    = 9'h060;
	localparam logic [3:0] IDLE_BITS     = 4'hb;
	localparam logic [7:0] BIT_TQ_NOM    = 8'h0a;

	typedef struct packed {
		logic warn;
		logic bus_off_flag;
		logic suspend_acknowledge;
	} cnfc_stat_type;

	typedef struct packed {
		logic transmit_request_flag;
		logic new_data_flag;
	} cnfc_msg_type;

	typedef enum logic [1:0] {
		NODE_ACTIVE,
		NODE_BUS_OFF_FLAG_RECOV
	} cnfc_node_type;

endpackage
`default_nettype wire

// >>> design/cnfc_node.sv
`timescale 1ns/10ps
`default_nettype none
module cnfc_node (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// can pins and protocol engine events
	input  wire logic        rxd_i,
	input  wire logic        bit_tick_i,
	input  wire logic        remote_match_i,
	input  wire logic        tx_select_i,
	input  wire logic        arb_lost_i,
	input  wire logic        tx_done_i,
	// node outputs
	output logic             init_o,
	output logic             irq_o
);

	logic rx_meta_q, rx_sync_q;
	logic [7:0]  warn_lvl_q, warn_lvl_d;
	logic [8:0]  tec_q, tec_d, rec_q, rec_d;
	logic [7:0]  idle_cnt_q, idle_cnt_d;
	logic [3:0]  rec_bits_q, rec_bits_d;
	logic [15:0] tstamp_q, tstamp_d;
	logic        init_q, init_d, dis_q, dis_d, stt_q, stt_d;
	logic [3:0]  irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, irq_set;
	cnfc_pkg::cnfc_stat_type stat_q, stat_d;
	cnfc_pkg::cnfc_msg_type  msg_q, msg_d;
	cnfc_pkg::cnfc_node_type node_q, node_d;
	logic        pend_q, pend_d;
	logic        wr, rd, bus_idle, idle_evt;
	logic        ev_txerr, ev_rxerr, ev_oktx;
	logic [31:0] prdata_d;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// rxd seen only through two flops; the bit logic reads rx_sync_q
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end else begin
			rx_meta_q <= rxd_i;
			rx_sync_q <= rx_meta_q;
		end
	end

	assign wr       = psel_i && penable_i && pwrite_i;
	assign rd       = psel_i && !pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	assign ev_txerr = wr && hit(paddr_i, cnfc_pkg::EVT_OFS) && pwdata_i[cnfc_pkg::EVT_TXERR_BIT];
	assign ev_rxerr = wr && hit(paddr_i, cnfc_pkg::EVT_OFS) && pwdata_i[cnfc_pkg::EVT_RXERR_BIT];
	assign ev_oktx  = wr && hit(paddr_i, cnfc_pkg::EVT_OFS) && pwdata_i[cnfc_pkg::EVT_OKTX_BIT];
	// idle: eleven recessive bit times in a row
	assign bus_idle = (rec_bits_q == cnfc_pkg::IDLE_BITS);
	assign idle_evt = bit_tick_i && rx_sync_q && (rec_bits_q == cnfc_pkg::IDLE_BITS - 4'h1);

	always_comb begin
		rec_bits_d = rec_bits_q;
		if (bit_tick_i) begin
			if (!rx_sync_q)
				rec_bits_d = 4'h0;
			else if (rec_bits_q != cnfc_pkg::IDLE_BITS)
				rec_bits_d = rec_bits_q + 4'h1;
		end
		// stamp moves only on real bit ticks, so resync stretch is included
		tstamp_d = bit_tick_i ? tstamp_q + 16'h0001 : tstamp_q;
	end

	always_comb begin
		warn_lvl_d = warn_lvl_q;
		init_d     = init_q;
		dis_d      = dis_q;
		stt_d      = stt_q;
		irq_mask_d = irq_mask_q;
		tec_d      = tec_q;
		rec_d      = rec_q;
		idle_cnt_d = idle_cnt_q;
		stat_d     = stat_q;
		node_d     = node_q;
		irq_set    = 4'h0;
		if (wr && hit(paddr_i, cnfc_pkg::NODE_CTRL_OFS)) begin
			init_d = pwdata_i[cnfc_pkg::CTRL_INIT_BIT];
			dis_d  = pwdata_i[cnfc_pkg::CTRL_DIS_BIT];
			stt_d  = pwdata_i[cnfc_pkg::CTRL_STT_BIT];
		end else if (wr && hit(paddr_i, cnfc_pkg::WARN_LVL_OFS)) begin
			warn_lvl_d = pwdata_i[7:0];
		end else if (wr && hit(paddr_i, cnfc_pkg::IRQ_MASK_OFS)) begin
			irq_mask_d = pwdata_i[3:0];
		end
		// suspend ack once disabled and bus idle; cleared with disable
		stat_d.suspend_acknowledge = dis_q && (stat_q.suspend_acknowledge || bus_idle);
		case (node_q)
			cnfc_pkg::NODE_ACTIVE: begin
				if (ev_txerr)
					tec_d = tec_q + 9'h008;
				else if (ev_oktx && tec_q != 9'h000)
					tec_d = tec_q - 9'h001;
				if (ev_rxerr && rec_q < 9'h0ff)
					rec_d = rec_q + 9'h001;
				if (!stat_q.warn && (tec_d >= {1'b0, warn_lvl_q} || rec_d >= {1'b0, warn_lvl_q})) begin
					stat_d.warn = 1'b1;
					irq_set[cnfc_pkg::IRQ_WARN_BIT] = 1'b1;
				end
				if (tec_d > cnfc_pkg::TEC_BUS_OFF_FLAG_LIM) begin
					tec_d       = cnfc_pkg::ERR_BUS_OFF_FLAG_LOAD;
					rec_d       = cnfc_pkg::ERR_BUS_OFF_FLAG_LOAD;
					init_d      = 1'b1;
					stat_d.bus_off_flag = 1'b1;
					stat_d.warn = 1'b0;
					idle_cnt_d  = 8'h00;
					irq_set[cnfc_pkg::IRQ_BUS_OFF_FLAG_BIT] = 1'b1;
					node_d      = cnfc_pkg::NODE_BUS_OFF_FLAG_RECOV;
				end
			end
			cnfc_pkg::NODE_BUS_OFF_FLAG_RECOV: begin
				if (idle_evt) begin
					rec_d      = rec_q + 9'h001;
					idle_cnt_d = idle_cnt_q + 8'h01;
					if (rec_d == cnfc_pkg::RECOV_WARN) begin
						stat_d.warn = 1'b1;
						irq_set[cnfc_pkg::IRQ_PREW_BIT] = 1'b1;
					end
					if (idle_cnt_d == cnfc_pkg::RECOV_IDLES) begin
						stat_d.warn = 1'b0;
						stat_d.bus_off_flag = 1'b0;
						tec_d       = 9'h000;
						rec_d       = 9'h000;
						irq_set[cnfc_pkg::IRQ_ALERT_BIT] = 1'b1;
						node_d      = cnfc_pkg::NODE_ACTIVE; // init left set
					end
				end
			end
			default: node_d = cnfc_pkg::NODE_ACTIVE;
		endcase
		// sticky status: a set in the clearing cycle wins
		irq_stat_d = irq_stat_q;
		if (wr && hit(paddr_i, cnfc_pkg::IRQ_STAT_OFS))
			irq_stat_d = irq_stat_q & ~pwdata_i[3:0];
		irq_stat_d = irq_stat_d | irq_set;
	end

	// message object: remote frame setup, single trial and double request
	always_comb begin
		msg_d  = msg_q;
		pend_d = pend_q;
		if (wr && hit(paddr_i, cnfc_pkg::MSG_CTRL_OFS)) begin
			msg_d.transmit_request_flag   = pwdata_i[cnfc_pkg::MSG_TRANSMIT_REQUEST_FLAG_BIT];
			msg_d.new_data_flag = pwdata_i[cnfc_pkg::MSG_NEW_DATA_FLAG_BIT];
		end
		if (tx_select_i && stt_q)
			msg_d.transmit_request_flag = 1'b0;
		if (tx_done_i) begin
			// an extra frame is owed only for a request that came in arbitration
			msg_d.transmit_request_flag = pend_q;
			pend_d     = 1'b0;
		end
		if (remote_match_i) begin
			if (arb_lost_i && msg_q.transmit_request_flag) begin
				msg_d.new_data_flag = 1'b1;
				pend_d       = 1'b1;
			end else begin
				msg_d.transmit_request_flag   = 1'b1;
				msg_d.new_data_flag = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			warn_lvl_q <= cnfc_pkg::WARN_LVL_RST;
			tec_q      <= 9'h000;
			rec_q      <= 9'h000;
			idle_cnt_q <= 8'h00;
			rec_bits_q <= 4'h0;
			tstamp_q   <= 16'h0000;
			init_q     <= 1'b1;
			dis_q      <= 1'b0;
			stt_q      <= 1'b0;
			irq_stat_q <= 4'h0;
			irq_mask_q <= 4'h0;
			stat_q     <= '0;
			msg_q      <= '0;
			node_q     <= cnfc_pkg::NODE_ACTIVE;
			pend_q     <= 1'b0;
			prdata_o   <= 32'h00000000;
		end else begin
			warn_lvl_q <= warn_lvl_d;
			tec_q      <= tec_d;
			rec_q      <= rec_d;
			idle_cnt_q <= idle_cnt_d;
			rec_bits_q <= rec_bits_d;
			tstamp_q   <= tstamp_d;
			init_q     <= init_d;
			dis_q      <= dis_d;
			stt_q      <= stt_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			stat_q     <= stat_d;
			msg_q      <= msg_d;
			node_q     <= node_d;
			pend_q     <= pend_d;
			prdata_o   <= prdata_d;
		end
	end

	// read data is latched in the setup cycle, so the access phase needs no wait state
	always_comb begin
		prdata_d = prdata_o;
		if (rd && !penable_i) begin
			if (hit(paddr_i, cnfc_pkg::NODE_CTRL_OFS))
				prdata_d = {29'h0, stt_q, dis_q, init_q};
			else if (hit(paddr_i, cnfc_pkg::NODE_STAT_OFS))
				prdata_d = {29'h0, stat_q.suspend_acknowledge, stat_q.bus_off_flag, stat_q.warn};
			else if (hit(paddr_i, cnfc_pkg::ERR_CNT_OFS))
				prdata_d = {7'h0, rec_q, 7'h0, tec_q};
			else if (hit(paddr_i, cnfc_pkg::WARN_LVL_OFS))
				prdata_d = {24'h0, warn_lvl_q};
			else if (hit(paddr_i, cnfc_pkg::IRQ_STAT_OFS))
				prdata_d = {28'h0, irq_stat_q};
			else if (hit(paddr_i, cnfc_pkg::IRQ_MASK_OFS))
				prdata_d = {28'h0, irq_mask_q};
			else if (hit(paddr_i, cnfc_pkg::TSTAMP_OFS))
				prdata_d = {16'h0, tstamp_q};
			else if (hit(paddr_i, cnfc_pkg::MSG_CTRL_OFS))
				prdata_d = {30'h0, msg_q.new_data_flag, msg_q.transmit_request_flag};
			else
				prdata_d = 32'h00000000;
		end
	end

	assign init_o = init_q;
	assign irq_o  = |(irq_stat_q & irq_mask_q);

	a_sync_delay: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rx_sync_q == $past(rxd_i, 2)) else $error("rx sync delay wrong");
	a_warn_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(rstn_i) |-> warn_lvl_q == 8'h60) else $error("warning level reset wrong");
	a_bus_off_flag_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
		node_q == cnfc_pkg::NODE_ACTIVE && tec_d > 9'h0ff |=> tec_q == 9'h001 && rec_q == 9'h001 && init_q
		&& stat_q.bus_off_flag && irq_stat_q[1]) else $error("bus-off entry wrong");
	a_recov_inc: assert property (@(posedge clk_i) disable iff (!rstn_i)
		node_q == cnfc_pkg::NODE_BUS_OFF_FLAG_RECOV && idle_evt && idle_cnt_q != 8'h7f |=> rec_q == $past(rec_q) + 9'h001)
		else $error("recovery count not advanced");
	a_prewarn: assert property (@(posedge clk_i) disable iff (!rstn_i)
		node_q == cnfc_pkg::NODE_BUS_OFF_FLAG_RECOV && idle_evt && rec_q == 9'h05f |=> stat_q.warn && stat_q.bus_off_flag
		&& irq_stat_q[2]) else $error("pre-warning missing");
	a_recov_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
		node_q == cnfc_pkg::NODE_BUS_OFF_FLAG_RECOV && idle_evt && idle_cnt_q == 8'h7f |=> !stat_q.bus_off_flag && !stat_q.warn
		&& irq_stat_q[3] && init_q) else $error("recovery end wrong");
	a_suspend_acknowledge_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(stat_q.suspend_acknowledge) |-> dis_q && $past(bus_idle)) else $error("suspend ack without idle");
	a_stt_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tx_select_i && stt_q && !remote_match_i |=> !msg_q.transmit_request_flag) else $error("single trial request kept");
	a_remote_setup: assert property (@(posedge clk_i) disable iff (!rstn_i)
		remote_match_i && !(arb_lost_i && msg_q.transmit_request_flag) |=> msg_q.transmit_request_flag && !msg_q.new_data_flag)
		else $error("remote setup wrong");
	a_stamp_tick: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!bit_tick_i |=> $stable(tstamp_q)) else $error("stamp moved without bit");
	a_stamp_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
		bit_tick_i |=> tstamp_q == $past(tstamp_q) + 16'h0001) else $error("stamp missed a bit");
	a_warn_raise: assert property (@(posedge clk_i) disable iff (!rstn_i)
		node_q == cnfc_pkg::NODE_ACTIVE && !stat_q.warn && tec_d >= {1'b0, warn_lvl_q} && tec_d <= 9'h0ff
		|=> stat_q.warn && irq_stat_q[cnfc_pkg::IRQ_WARN_BIT]) else $error("warning not raised");
	a_sticky_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		irq_set != 4'h0 |=> (irq_stat_q & $past(irq_set)) == $past(irq_set)) else $error("interrupt event lost");
	a_suspend_acknowledge_drop: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!dis_q |=> !stat_q.suspend_acknowledge) else $error("suspend ack without disable");
	a_frame_limit: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tx_done_i && !pend_q && !remote_match_i |=> !msg_q.transmit_request_flag) else $error("frame owed without request");

	c_bus_off_flag: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(stat_q.bus_off_flag));
	c_alert: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_stat_q[3]));
	c_double: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(pend_q));
	c_suspend_acknowledge: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(stat_q.suspend_acknowledge));
	c_prewarn: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_stat_q[2]));

endmodule
`default_nettype wire

// >>> tb/cnfc_can_far.sv
`timescale 1ns/10ps
`default_nettype none
module cnfc_can_far (
	// clock, reset and traffic control
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic busy_i,
	// bus side
	output logic      rxd_o,
	output logic      bit_tick_o
);
	integer seed = 38;
	int     len;
	int     cnt;
	int     bitn;
	// bits last 9 to 11 clocks, as resynchronization leaves them
	// quiet bus: 12 recessive bits then one dominant, so each gap is exactly one idle period
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rxd_o <= 1'b1;
			bit_tick_o <= 1'b0;
			len <= 10;
			cnt <= 0;
			bitn <= 0;
		end else begin
			// sample point mid-bit, well clear of the two-flop delay
			bit_tick_o <= (cnt == 4);
			cnt <= (cnt == len - 1) ? 0 : cnt + 1;
			if (cnt == len - 1) begin
				len <= 9 + int'($unsigned($random(seed)) % 3);
				bitn <= (bitn == 12) ? 0 : bitn + 1;
				rxd_o <= busy_i ? ~rxd_o : (bitn != 11);
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/cnfc_node_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cnfc_node_bench;
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] msk;
	} cnfc_note_type;
	logic          clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic          rxd_i, bit_tick_i, arb_lost_i, init_o, irq_o, bus_busy;
	logic [7:0]    paddr_i, lvl;
	logic [31:0]   pwdata_i, prdata_o, q;
	logic [2:0]    ev;
	cnfc_note_type notes[$];
	cnfc_note_type nt;
	integer        seed = 38;
	int            miscompares = 0;
	int            check_count = 0;
	int            tec, n, ticks, run;
	int            idles = 0;

	cnfc_node cnfc_node_i (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .rxd_i(rxd_i), .bit_tick_i(bit_tick_i), .remote_match_i(ev[1]),
		.tx_select_i(ev[0]), .arb_lost_i(arb_lost_i), .tx_done_i(ev[2]), .init_o(init_o), .irq_o(irq_o));
	cnfc_can_far cnfc_can_far_i (.clk_i(clk_i), .rstn_i(rstn_i), .busy_i(bus_busy), .rxd_o(rxd_i),
		.bit_tick_o(bit_tick_i));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// bit times and idle gaps as the bus really shows them
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ticks <= 0;
			run <= 0;
		end else if (bit_tick_i) begin
			ticks <= ticks + 1;
			run <= rxd_i ? run + 1 : 0;
			if (rxd_i && run == 10) idles <= idles + 1;
		end
	end

	// read results against the oldest note; an empty queue can never match
	always @(posedge clk_i) begin
		if (psel_i && penable_i && pready_o === 1'b1) begin
			chk("pslverr_o", 32'h0, {31'h0, pslverr_o});
			if (!pwrite_i) begin
				nt = (notes.size() == 0) ? cnfc_note_type'({32'hffff_ffff, 32'h0}) : notes.pop_front();
				chk("prdata", nt.exp, prdata_o & nt.msk);
			end
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic hang();
		miscompares++;
		$display("CHECK FAILED wait expected event seen none");
		wrap_up();
	endtask

	// ts: expectation is the bit count at the setup edge, where read data is latched
	task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d, input cnfc_note_type e,
		input logic ts);
		int k;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= we;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		if (!we) notes.push_back(ts ? cnfc_note_type'({ticks, 32'hffff_ffff}) : e);
		penable_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 20);
		if (pready_o !== 1'b1) hang();
		q = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, '0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, cnfc_note_type'({e, m}), 1'b0);
	endtask

	task automatic wait_irq();
		int k;
		k = 0;
		while (irq_o !== 1'b1 && k < 30000) begin
			@(posedge clk_i);
			k++;
		end
		if (irq_o !== 1'b1) hang();
	endtask

	// bit 0 object selected, bit 1 remote match, bit 2 frame sent
	task automatic pulse(input logic [2:0] k);
		ev <= k;
		@(posedge clk_i);
		ev <= 3'h0;
		@(posedge clk_i);
	endtask

	initial begin
		{rstn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, ev, arb_lost_i} = '0;
		bus_busy = 1'b1;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		rd(cnfc_pkg::WARN_LVL_OFS, 32'h60, 32'hff);
		rd(8'h40, 32'h0, 32'hffff_ffff);
		apb(1'b0, cnfc_pkg::TSTAMP_OFS, 32'h0, '0, 1'b1);
		$display("test reset done");
		wr(cnfc_pkg::NODE_CTRL_OFS, 32'h0);
		wr(cnfc_pkg::IRQ_MASK_OFS, 32'h1);
		lvl = 8'h08 + 8'($unsigned($random(seed)) % 56);
		wr(cnfc_pkg::WARN_LVL_OFS, {24'h0, lvl});
		tec = 0;
		while (tec + 8 < lvl) begin
			wr(cnfc_pkg::EVT_OFS, 32'h1);
			tec += 8;
		end
		rd(cnfc_pkg::NODE_STAT_OFS, 32'h0, 32'h1);
		chk("irq_o", 32'h0, {31'h0, irq_o});
		wr(cnfc_pkg::EVT_OFS, 32'h1);
		tec += 8;
		rd(cnfc_pkg::NODE_STAT_OFS, 32'h1, 32'h1);
		chk("irq_o", 32'h1, {31'h0, irq_o});
		wr(cnfc_pkg::IRQ_MASK_OFS, 32'h0);
		chk("irq_o", 32'h0, {31'h0, irq_o});
		wr(cnfc_pkg::IRQ_MASK_OFS, 32'h1);
		chk("irq_o", 32'h1, {31'h0, irq_o});
		wr(cnfc_pkg::IRQ_STAT_OFS, 32'h1);
		chk("irq_o", 32'h0, {31'h0, irq_o});
		$display("test warning done");
		wr(cnfc_pkg::IRQ_MASK_OFS, 32'h2);
		while (tec <= 255) begin
			wr(cnfc_pkg::EVT_OFS, 32'h1);
			tec += 8;
		end
		rd(cnfc_pkg::ERR_CNT_OFS, 32'h0001_0001, 32'h01ff_01ff);
		rd(cnfc_pkg::NODE_STAT_OFS, 32'h2, 32'h2);
		chk("init_o", 32'h1, {31'h0, init_o});
		chk("irq_o", 32'h1, {31'h0, irq_o});
		wr(cnfc_pkg::IRQ_STAT_OFS, 32'hf);
		wr(cnfc_pkg::IRQ_MASK_OFS, 32'h4);
		idles = 0;
		bus_busy <= 1'b0;
		wait_irq();
		chk("idles to prewarn", 32'h5f, 32'(idles));
		rd(cnfc_pkg::ERR_CNT_OFS, 32'h0060_0000, 32'h01ff_0000);
		rd(cnfc_pkg::NODE_STAT_OFS, 32'h3, 32'h3);
		wr(cnfc_pkg::IRQ_MASK_OFS, 32'h8);
		wait_irq();
		chk("idles to alert", 32'h80, 32'(idles));
		rd(cnfc_pkg::NODE_STAT_OFS, 32'h0, 32'h3);
		chk("init_o", 32'h1, {31'h0, init_o});
		$display("test bus-off done");
		for (int s = 0; s < 2; s++) begin
			wr(cnfc_pkg::NODE_CTRL_OFS, 32'(s) << 2);
			wr(cnfc_pkg::MSG_CTRL_OFS, 32'h1);
			pulse(3'h1);
			rd(cnfc_pkg::MSG_CTRL_OFS, 32'(1 - s), 32'h1);
		end
		wr(cnfc_pkg::MSG_CTRL_OFS, 32'h2);
		pulse(3'h2);
		rd(cnfc_pkg::MSG_CTRL_OFS, 32'h1, 32'h3);
		arb_lost_i <= 1'b1;
		pulse(3'h2);
		rd(cnfc_pkg::MSG_CTRL_OFS, 32'h3, 32'h3);
		arb_lost_i <= 1'b0;
		pulse(3'h4);
		rd(cnfc_pkg::MSG_CTRL_OFS, 32'h3, 32'h3);
		pulse(3'h4);
		rd(cnfc_pkg::MSG_CTRL_OFS, 32'h0, 32'h1);
		$display("test message object done");
		// a dominant bit must reach the node first, or the old idle state would acknowledge at once
		bus_busy <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (!(bit_tick_i === 1'b1 && rxd_i === 1'b0) && n < 500);
		if (!(bit_tick_i === 1'b1 && rxd_i === 1'b0)) hang();
		@(posedge clk_i);
		wr(cnfc_pkg::NODE_CTRL_OFS, 32'h1);
		wr(cnfc_pkg::NODE_CTRL_OFS, 32'h3);
		rd(cnfc_pkg::NODE_STAT_OFS, 32'h0, 32'h4);
		bus_busy <= 1'b0;
		q = 32'h0;
		n = 0;
		while (q[2] !== 1'b1 && n < 400) begin
			rd(cnfc_pkg::NODE_STAT_OFS, 32'h0, 32'h0);
			n++;
		end
		if (q[2] !== 1'b1) hang();
		rd(cnfc_pkg::NODE_STAT_OFS, 32'h4, 32'h4);
		apb(1'b0, cnfc_pkg::TSTAMP_OFS, 32'h0, '0, 1'b1);
		$display("test disable done");
		chk("irq_o", 32'h1, {31'h0, irq_o});
		rstn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("init_o", 32'h1, {31'h0, init_o});
		chk("irq_o", 32'h0, {31'h0, irq_o});
		rstn_i <= 1'b1;
		@(posedge clk_i);
		rd(cnfc_pkg::NODE_CTRL_OFS, 32'h1, 32'h7);
		rd(cnfc_pkg::WARN_LVL_OFS, 32'h60, 32'hff);
		apb(1'b0, cnfc_pkg::TSTAMP_OFS, 32'h0, '0, 1'b1);
		$display("test reset again done");
		wrap_up();
	end
endmodule
`default_nettype wire
